/* tcr_pkg.sv */
// constants, codes and carrier types of the camera configuration register bank
// assumes a single 50 MHz clock domain; register indices are word indices on the bus
package tcr_pkg;

	localparam int IDX_W = 9;

	// register indices (byte address is four times the index)
	localparam logic [8:0] IDX_MODE = 9'h001;
	localparam logic [8:0] IDX_STATUS = 9'h003;
	localparam logic [8:0] IDX_IMG_FMT = 9'h004;
	localparam logic [8:0] IDX_MOD_FREQ = 9'h009;
	localparam logic [8:0] IDX_FRAME_RATE = 9'h00A;
	localparam logic [8:0] IDX_LENS_ID = 9'h00B;
	localparam logic [8:0] IDX_SERIAL_LO = 9'h00C;
	localparam logic [8:0] IDX_SERIAL_HI = 9'h00D;
	localparam logic [8:0] IDX_FRAME_CNT = 9'h00E;
	localparam logic [8:0] IDX_CAL_CMD = 9'h00F;
	localparam logic [8:0] IDX_THR_LO = 9'h010;
	localparam logic [8:0] IDX_THR_HI = 9'h011;
	localparam logic [8:0] IDX_ILLUM_TEMP = 9'h01B;
	localparam logic [8:0] IDX_CAL_EXT = 9'h021;
	localparam logic [8:0] IDX_UNLOCK = 9'h022;
	localparam logic [8:0] IDX_TEMP_LIMIT = 9'h024;
	localparam logic [8:0] IDX_HFOV = 9'h026;
	localparam logic [8:0] IDX_VFOV = 9'h027;
	localparam logic [8:0] IDX_CMD_EXEC = 9'h033;
	localparam logic [8:0] IDX_SEQ_CNT = 9'h050;
	localparam logic [8:0] IDX_IRQ_STAT = 9'h051;
	localparam logic [8:0] IDX_IRQ_MASK = 9'h052;
	localparam logic [8:0] IDX_TEST_CFG = 9'h1C0;

	// values after reset
	localparam logic [15:0] RST_MOD_FREQ = 16'h07D0;
	localparam logic [15:0] RST_FRAME_RATE = 16'h0028;
	localparam logic [15:0] RST_LENS_ID = 16'h0000;
	localparam logic [15:0] RST_THR_LO = 16'h03E8;
	localparam logic [15:0] RST_THR_HI = 16'hEA60;
	localparam logic [15:0] RST_TEMP_LIMIT = 16'h1B58;
	localparam logic [15:0] RST_SEQ_CNT = 16'h0001;
	localparam logic RST_VIDEO = 1'b1;

	// calibration command and status codes
	localparam logic [7:0] CMD_FPN_CAL = 8'h0D;
	localparam logic [7:0] CMD_FPN_ERASE = 8'h10;
	localparam logic [7:0] ST_IDLE = 8'h00;
	localparam logic [7:0] ST_FPN_CAL = 8'h13;
	localparam logic [7:0] ST_ERASING = 8'h14;
	localparam logic [7:0] ST_DONE = 8'hA1;
	localparam logic [7:0] ST_BAD_MODE = 8'hF6;
	localparam logic [7:0] ST_BAD_FREQ = 8'hF8;
	localparam logic [7:0] ST_GENERIC = 8'hFF;

	// image formats that carry distances
	localparam logic [7:0] FMT_DIST_AMP = 8'h00;
	localparam logic [7:0] FMT_DIST_XYZ = 8'h09;
	localparam logic [7:0] FMT_DIST = 8'h0C;
	localparam logic [7:0] FMT_RAW_DIST = 8'h0D;

	// field positions
	localparam int BIT_MODE_VIDEO = 0;
	localparam int BIT_MODE_TRIG = 4;
	localparam int BIT_MODE_CLR = 6;
	localparam int BIT_STAT_CAL = 2;
	localparam int BIT_STAT_TSENS = 3;
	localparam int BIT_STAT_CALMISS = 5;
	localparam int BIT_STAT_OVT = 9;
	localparam int BIT_EXT_ERR = 10;
	localparam int BIT_EXT_NO_FPN = 12;
	localparam int BIT_EXT_NO_LENS = 14;
	localparam int IMG_FMT_LSB = 3;
	localparam int IMG_FMT_MSB = 10;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_CAL_DONE = 1;
	localparam int IRQ_CAL_ERR = 2;
	localparam int IRQ_OVT = 3;

	// temperature and unlock values
	localparam logic [15:0] TEMP_ABSENT = 16'hFFFF;
	localparam logic [15:0] TEMP_HYST = 16'h00C8;
	localparam logic [15:0] UNLOCK_FLASH = 16'h4877;
	localparam logic [15:0] UNLOCK_TEST = 16'h5E6B;

	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_ERASE} tcr_cal_state_e;

	typedef struct packed {
		logic [31:0] serial;
		logic [15:0] illum_temp;
		logic temp_present;
		logic [15:0] hfov;
		logic [15:0] vfov;
		logic fpn_stored;
		logic lens_cal_stored;
		logic mod_freq_ok;
		logic [15:0] seq0_mod_freq;
	} tcr_sense_s;

	typedef struct packed {
		logic illum_en;
		logic stream_en;
		logic video_mode;
		logic [7:0] img_fmt;
		logic [15:0] mod_freq;
		logic [15:0] frame_rate;
		logic [15:0] lens_id;
		logic [15:0] seq_cnt;
		logic [15:0] test_cfg;
		logic test_unlocked;
	} tcr_ctrl_s;

	typedef struct packed {
		logic start;
		logic erase;
		logic [15:0] freq;
	} tcr_cal_req_s;

endpackage

/* tcr_cal_seq.sv */
// calibration command sequencer: checks preconditions, starts the engine, tracks its status code
// assumes the engine answers each start or erase with one done or fail pulse
module tcr_cal_seq (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cmd_wr_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic dist_fmt_i,
	input wire logic video_i,
	input wire logic freq_ok_i,
	input wire logic one_seq_i,
	input wire logic [15:0] cur_freq_i,
	input wire logic [15:0] seq0_freq_i,
	input wire logic done_i,
	input wire logic fail_i,
	input wire logic clr_i,
	output tcr_pkg::tcr_cal_req_s req_o,
	output logic [7:0] code_o,
	output logic busy_o,
	output logic err_o,
	output logic done_pulse_o,
	output logic err_pulse_o
);

	tcr_pkg::tcr_cal_state_e state_reg;
	logic idle_cmd;

	assign idle_cmd = cmd_wr_i && (state_reg == tcr_pkg::CAL_IDLE);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= tcr_pkg::CAL_IDLE;
			req_o <= '0;
			code_o <= tcr_pkg::ST_IDLE;
			err_o <= 1'b0;
			done_pulse_o <= 1'b0;
			err_pulse_o <= 1'b0;
		end else begin
			req_o.start <= 1'b0;
			req_o.erase <= 1'b0;
			done_pulse_o <= 1'b0;
			err_pulse_o <= 1'b0;
			case (state_reg)
				tcr_pkg::CAL_IDLE: begin
					if (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_CAL) begin
						if (!(dist_fmt_i && video_i)) begin
							code_o <= tcr_pkg::ST_BAD_MODE;
							err_o <= 1'b1;
							err_pulse_o <= 1'b1;
						end else if (!freq_ok_i) begin
							code_o <= tcr_pkg::ST_BAD_FREQ;
							err_o <= 1'b1;
							err_pulse_o <= 1'b1;
						end else if (!one_seq_i) begin
							// more than one sequence leaves the frequency ambiguous
							code_o <= tcr_pkg::ST_GENERIC;
							err_o <= 1'b1;
							err_pulse_o <= 1'b1;
						end else begin
							req_o.start <= 1'b1;
							req_o.freq <= cur_freq_i;
							code_o <= tcr_pkg::ST_FPN_CAL;
							err_o <= 1'b0;
							state_reg <= tcr_pkg::CAL_RUN;
						end
					end else if (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_ERASE) begin
						req_o.erase <= 1'b1;
						req_o.freq <= seq0_freq_i;
						code_o <= tcr_pkg::ST_ERASING;
						err_o <= 1'b0;
						state_reg <= tcr_pkg::CAL_ERASE;
					end else if (clr_i) begin
						code_o <= tcr_pkg::ST_IDLE;
						err_o <= 1'b0;
					end
				end
				tcr_pkg::CAL_RUN, tcr_pkg::CAL_ERASE: begin
					if (fail_i) begin
						code_o <= tcr_pkg::ST_GENERIC;
						err_o <= 1'b1;
						err_pulse_o <= 1'b1;
						state_reg <= tcr_pkg::CAL_IDLE;
					end else if (done_i) begin
						code_o <= tcr_pkg::ST_DONE;
						done_pulse_o <= 1'b1;
						state_reg <= tcr_pkg::CAL_IDLE;
					end
				end
				default: state_reg <= tcr_pkg::CAL_IDLE;
			endcase
		end
	end

	assign busy_o = (state_reg != tcr_pkg::CAL_IDLE);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	AST_BAD_MODE: assert property (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_CAL
		&& !(dist_fmt_i && video_i) |=> code_o == tcr_pkg::ST_BAD_MODE && err_o && !req_o.start)
		else $error("missing mode did not give code 246");
	AST_BAD_FREQ: assert property (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_CAL
		&& dist_fmt_i && video_i && !freq_ok_i |=> code_o == tcr_pkg::ST_BAD_FREQ && err_o)
		else $error("bad frequency did not give code 248");
	AST_START_CUR_FREQ: assert property (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_CAL
		&& dist_fmt_i && video_i && freq_ok_i && one_seq_i
		|=> req_o.start && req_o.freq == $past(cur_freq_i) ##1 !req_o.start)
		else $error("calibration not started at current frequency");
	AST_ERASE_SEQ0: assert property (idle_cmd && cmd_code_i == tcr_pkg::CMD_FPN_ERASE
		|=> req_o.erase && req_o.freq == $past(seq0_freq_i) && code_o == tcr_pkg::ST_ERASING)
		else $error("erase not issued for first sequence frequency");
	AST_FAIL_CODE: assert property (busy_o && fail_i |=> code_o == tcr_pkg::ST_GENERIC && err_o && !busy_o)
		else $error("engine failure did not give code 255");
	AST_CLEAR_ZERO: assert property (!busy_o && !cmd_wr_i && clr_i |=> code_o == tcr_pkg::ST_IDLE && !err_o)
		else $error("status code not zero after clear");

	CV_CAL_DONE: cover property (req_o.start ##[1:20] done_pulse_o);
	CV_ERASE: cover property (req_o.erase ##[1:20] done_pulse_o);

endmodule

/* tcr_config_regs.sv */
// configuration and status register bank of a time-of-flight camera, AHB-Lite slave
// assumes one 50 MHz clock; sensor readouts arrive synchronous to it; reads take one wait state
//
// Summary of operation
// - modulation frequency in 10 kHz units, reset 2000
// - serial number read as two 16-bit halves
// - frame counter counts every captured frame
// - code 13 starts calibration at current frequency
// - code 16 erases data at first-sequence frequency
// - distance valid only between amplitude thresholds
// - temperature in 0.01 C, all ones if absent
// - code 246 without distance format or video
// - code 248 bad frequency, 255 generic failure
// - extended status bits error, no noise, no lens
// - flash operations need unlock value 0x4877
// - test commands need unlock value 0x5E6B
// - temperature limit in 0.01 C, reset 7000
// - fields of view read-only in 0.01 degree
// - lens opening angle identifier is read-write
// - over-temperature stops illumination, sets status bit 9
module tcr_config_regs #(
	parameter int IDX_W = tcr_pkg::IDX_W
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire tcr_pkg::tcr_sense_s sense_i,
	input wire logic frame_captured_i,
	input wire logic [15:0] pixel_amp_i,
	input wire logic cal_done_i,
	input wire logic cal_fail_i,
	output logic pixel_valid_o,
	output tcr_pkg::tcr_ctrl_s ctrl_o,
	output tcr_pkg::tcr_cal_req_s cal_req_o,
	output logic manual_trigger_o,
	output logic flash_op_o,
	output logic [15:0] flash_cmd_o,
	output logic irq_o
);
	// elaboration-time check: the index slice of haddr must fit and reach every mapped register
	if (IDX_W < tcr_pkg::IDX_W || IDX_W > 30) begin : g_idx_w_check
		$error("index width cannot hold the register map");
	end

	logic dp_wr_reg;
	logic rd_pend_reg;
	logic [IDX_W-1:0] dp_idx_reg;
	logic take;
	logic [15:0] wdat;
	logic video_reg;
	logic [7:0] img_fmt_reg;
	logic [15:0] mod_freq_reg;
	logic [15:0] frame_rate_reg;
	logic [15:0] lens_id_reg;
	logic [15:0] cal_cmd_reg;
	logic [15:0] thr_lo_reg;
	logic [15:0] thr_hi_reg;
	logic [15:0] unlock_reg;
	logic [15:0] temp_limit_reg;
	logic [15:0] seq_cnt_reg;
	logic [15:0] test_cfg_reg;
	logic [15:0] frame_cnt_reg;
	logic [15:0] temp_reg;
	logic [31:0] serial_reg;
	logic [15:0] hfov_reg;
	logic [15:0] vfov_reg;
	logic no_fpn_reg;
	logic no_lens_reg;
	logic tsens_err_reg;
	logic ovt_reg;
	logic ovt_next;
	logic [15:0] clear_lvl;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_mask_reg;
	logic [3:0] irq_ev;
	logic [15:0] rd_val;
	logic cal_busy;
	logic cal_err;
	logic cal_done_p;
	logic cal_err_p;
	logic [7:0] cal_code;
	logic clr_status;

	function automatic logic wr_to(input logic wr, input logic [IDX_W-1:0] cur, input logic [8:0] idx);
		return wr && (cur == IDX_W'(idx));
	endfunction
	function automatic logic is_dist_fmt(input logic [7:0] fmt);
		return fmt == tcr_pkg::FMT_DIST_AMP || fmt == tcr_pkg::FMT_DIST_XYZ
			|| fmt == tcr_pkg::FMT_DIST || fmt == tcr_pkg::FMT_RAW_DIST;
	endfunction

	assign take = hsel_i && htrans_i[1] && hready_i;
	assign wdat = hwdata_i[15:0];

	// bus slave: writes land at the end of the data phase, reads wait one cycle so they see them
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dp_wr_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			dp_idx_reg <= '0;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
			if (take) begin
				dp_idx_reg <= haddr_i[IDX_W+1:2];
				dp_wr_reg <= hwrite_i;
				rd_pend_reg <= !hwrite_i;
				hreadyout_o <= hwrite_i;
			end else begin
				dp_wr_reg <= 1'b0;
				rd_pend_reg <= 1'b0;
				hreadyout_o <= 1'b1;
				if (rd_pend_reg)
					hrdata_o <= {16'h0000, rd_val};
			end
		end
	end
	assign clr_status = wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_MODE) && wdat[tcr_pkg::BIT_MODE_CLR];

	// writable configuration; read-only indices have no write path at all
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			video_reg <= tcr_pkg::RST_VIDEO;
			img_fmt_reg <= 8'h00;
			mod_freq_reg <= tcr_pkg::RST_MOD_FREQ;
			frame_rate_reg <= tcr_pkg::RST_FRAME_RATE;
			lens_id_reg <= tcr_pkg::RST_LENS_ID;
			cal_cmd_reg <= 16'h0000;
			thr_lo_reg <= tcr_pkg::RST_THR_LO;
			thr_hi_reg <= tcr_pkg::RST_THR_HI;
			temp_limit_reg <= tcr_pkg::RST_TEMP_LIMIT;
			seq_cnt_reg <= tcr_pkg::RST_SEQ_CNT;
			irq_mask_reg <= 4'h0;
		end else begin
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_MODE))
				video_reg <= wdat[tcr_pkg::BIT_MODE_VIDEO];
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_IMG_FMT))
				img_fmt_reg <= wdat[tcr_pkg::IMG_FMT_MSB:tcr_pkg::IMG_FMT_LSB];
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_MOD_FREQ))
				mod_freq_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_FRAME_RATE))
				frame_rate_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_LENS_ID))
				lens_id_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_CAL_CMD))
				cal_cmd_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_THR_LO))
				thr_lo_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_THR_HI))
				thr_hi_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_TEMP_LIMIT))
				temp_limit_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_SEQ_CNT))
				seq_cnt_reg <= wdat;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_IRQ_MASK))
				irq_mask_reg <= wdat[3:0];
		end
	end

	// unlock word: the flash value is used up by one command execute write
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			unlock_reg <= 16'h0000;
			test_cfg_reg <= 16'h0000;
			flash_op_o <= 1'b0;
			flash_cmd_o <= 16'h0000;
		end else begin
			flash_op_o <= 1'b0;
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_UNLOCK)) begin
				unlock_reg <= wdat;
			end else if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_CMD_EXEC)
				&& unlock_reg == tcr_pkg::UNLOCK_FLASH) begin
				flash_op_o <= 1'b1;
				flash_cmd_o <= wdat;
				unlock_reg <= 16'h0000;
			end
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_TEST_CFG) && unlock_reg == tcr_pkg::UNLOCK_TEST)
				test_cfg_reg <= wdat;
		end
	end

	// sensor readouts and frame counter
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_cnt_reg <= 16'h0000;
			temp_reg <= tcr_pkg::TEMP_ABSENT;
			serial_reg <= 32'h0000_0000;
			hfov_reg <= 16'h0000;
			vfov_reg <= 16'h0000;
			no_fpn_reg <= 1'b1;
			no_lens_reg <= 1'b1;
			tsens_err_reg <= 1'b1;
		end else begin
			if (frame_captured_i)
				frame_cnt_reg <= frame_cnt_reg + 16'h0001;
			temp_reg <= sense_i.temp_present ? sense_i.illum_temp : tcr_pkg::TEMP_ABSENT;
			tsens_err_reg <= !sense_i.temp_present;
			serial_reg <= sense_i.serial;
			hfov_reg <= sense_i.hfov;
			vfov_reg <= sense_i.vfov;
			no_fpn_reg <= !sense_i.fpn_stored;
			no_lens_reg <= !sense_i.lens_cal_stored;
		end
	end

	// over-temperature with a 2 degree hysteresis; an absent sensor never trips it
	assign clear_lvl = (temp_limit_reg > tcr_pkg::TEMP_HYST) ? temp_limit_reg - tcr_pkg::TEMP_HYST : 16'h0000;
	always_comb begin
		ovt_next = ovt_reg;
		if (tsens_err_reg)
			ovt_next = 1'b0;
		else if (temp_reg > temp_limit_reg)
			ovt_next = 1'b1;
		else if (temp_reg < clear_lvl)
			ovt_next = 1'b0;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ovt_reg <= 1'b0;
			ctrl_o <= '0;
			manual_trigger_o <= 1'b0;
			pixel_valid_o <= 1'b0;
		end else begin
			ovt_reg <= ovt_next;
			ctrl_o.illum_en <= !ovt_reg;
			ctrl_o.stream_en <= !ovt_reg;
			ctrl_o.video_mode <= video_reg;
			ctrl_o.img_fmt <= img_fmt_reg;
			ctrl_o.mod_freq <= mod_freq_reg;
			ctrl_o.frame_rate <= frame_rate_reg;
			ctrl_o.lens_id <= lens_id_reg;
			ctrl_o.seq_cnt <= seq_cnt_reg;
			ctrl_o.test_cfg <= test_cfg_reg;
			ctrl_o.test_unlocked <= (unlock_reg == tcr_pkg::UNLOCK_TEST);
			manual_trigger_o <= wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_MODE)
				&& wdat[tcr_pkg::BIT_MODE_TRIG] && !wdat[tcr_pkg::BIT_MODE_VIDEO];
			pixel_valid_o <= (pixel_amp_i >= thr_lo_reg) && (pixel_amp_i <= thr_hi_reg);
		end
	end

	tcr_cal_seq u_cal (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cmd_wr_i(wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_CAL_CMD)),
		.cmd_code_i(wdat[7:0]),
		.dist_fmt_i(is_dist_fmt(img_fmt_reg)),
		.video_i(video_reg),
		.freq_ok_i(sense_i.mod_freq_ok),
		.one_seq_i(seq_cnt_reg == 16'h0001),
		.cur_freq_i(mod_freq_reg),
		.seq0_freq_i(sense_i.seq0_mod_freq),
		.done_i(cal_done_i),
		.fail_i(cal_fail_i),
		.clr_i(clr_status),
		.req_o(cal_req_o),
		.code_o(cal_code),
		.busy_o(cal_busy),
		.err_o(cal_err),
		.done_pulse_o(cal_done_p),
		.err_pulse_o(cal_err_p)
	);

	// sticky events; a new event in the clearing cycle survives the clear
	always_comb begin
		irq_ev = 4'h0;
		irq_ev[tcr_pkg::IRQ_FRAME] = frame_captured_i;
		irq_ev[tcr_pkg::IRQ_CAL_DONE] = cal_done_p;
		irq_ev[tcr_pkg::IRQ_CAL_ERR] = cal_err_p;
		irq_ev[tcr_pkg::IRQ_OVT] = ovt_next && !ovt_reg;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_reg <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			if (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_IRQ_STAT))
				irq_stat_reg <= (irq_stat_reg & ~wdat[3:0]) | irq_ev;
			else
				irq_stat_reg <= irq_stat_reg | irq_ev;
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// read mux; unmapped indices read as zero
	always_comb begin
		rd_val = 16'h0000;
		case (dp_idx_reg)
			IDX_W'(tcr_pkg::IDX_MODE): rd_val[tcr_pkg::BIT_MODE_VIDEO] = video_reg;
			IDX_W'(tcr_pkg::IDX_STATUS): begin
				rd_val[tcr_pkg::BIT_STAT_CAL] = cal_busy;
				rd_val[tcr_pkg::BIT_STAT_TSENS] = tsens_err_reg;
				rd_val[tcr_pkg::BIT_STAT_CALMISS] = no_fpn_reg || no_lens_reg;
				rd_val[tcr_pkg::BIT_STAT_OVT] = ovt_reg;
			end
			IDX_W'(tcr_pkg::IDX_IMG_FMT): rd_val[tcr_pkg::IMG_FMT_MSB:tcr_pkg::IMG_FMT_LSB] = img_fmt_reg;
			IDX_W'(tcr_pkg::IDX_MOD_FREQ): rd_val = mod_freq_reg;
			IDX_W'(tcr_pkg::IDX_FRAME_RATE): rd_val = frame_rate_reg;
			IDX_W'(tcr_pkg::IDX_LENS_ID): rd_val = lens_id_reg;
			IDX_W'(tcr_pkg::IDX_SERIAL_LO): rd_val = serial_reg[15:0];
			IDX_W'(tcr_pkg::IDX_SERIAL_HI): rd_val = serial_reg[31:16];
			IDX_W'(tcr_pkg::IDX_FRAME_CNT): rd_val = frame_cnt_reg;
			IDX_W'(tcr_pkg::IDX_CAL_CMD): rd_val = cal_cmd_reg;
			IDX_W'(tcr_pkg::IDX_THR_LO): rd_val = thr_lo_reg;
			IDX_W'(tcr_pkg::IDX_THR_HI): rd_val = thr_hi_reg;
			IDX_W'(tcr_pkg::IDX_ILLUM_TEMP): rd_val = temp_reg;
			IDX_W'(tcr_pkg::IDX_CAL_EXT): begin
				rd_val[7:0] = cal_code;
				rd_val[tcr_pkg::BIT_EXT_ERR] = cal_err;
				rd_val[tcr_pkg::BIT_EXT_NO_FPN] = no_fpn_reg;
				rd_val[tcr_pkg::BIT_EXT_NO_LENS] = no_lens_reg;
			end
			IDX_W'(tcr_pkg::IDX_UNLOCK): rd_val = unlock_reg;
			IDX_W'(tcr_pkg::IDX_TEMP_LIMIT): rd_val = temp_limit_reg;
			IDX_W'(tcr_pkg::IDX_HFOV): rd_val = hfov_reg;
			IDX_W'(tcr_pkg::IDX_VFOV): rd_val = vfov_reg;
			IDX_W'(tcr_pkg::IDX_CMD_EXEC): rd_val = flash_cmd_o;
			IDX_W'(tcr_pkg::IDX_SEQ_CNT): rd_val = seq_cnt_reg;
			IDX_W'(tcr_pkg::IDX_IRQ_STAT): rd_val[3:0] = irq_stat_reg;
			IDX_W'(tcr_pkg::IDX_IRQ_MASK): rd_val[3:0] = irq_mask_reg;
			IDX_W'(tcr_pkg::IDX_TEST_CFG): rd_val = test_cfg_reg;
			default: rd_val = 16'h0000;
		endcase
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	AST_FRAME_COUNT: assert property (frame_captured_i |=> frame_cnt_reg == $past(frame_cnt_reg) + 16'h0001)
		else $error("frame counter did not step by one");
	AST_RO_IGNORED: assert property (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_FRAME_CNT)
		&& !frame_captured_i |=> $stable(frame_cnt_reg))
		else $error("write changed the frame counter");
	AST_OVT_STOPS: assert property (ovt_reg |=> !ctrl_o.illum_en && !ctrl_o.stream_en)
		else $error("illumination still on during over-temperature");
	AST_OVT_TRIP: assert property (!tsens_err_reg && temp_reg > temp_limit_reg |=> ovt_reg ##1 !ctrl_o.illum_en)
		else $error("over-temperature not detected");
	AST_TEMP_ABSENT: assert property (!sense_i.temp_present |=> temp_reg == tcr_pkg::TEMP_ABSENT)
		else $error("absent sensor not reported as all ones");
	AST_PIX_VALID: assert property (pixel_valid_o
		== $past((pixel_amp_i >= thr_lo_reg) && (pixel_amp_i <= thr_hi_reg)))
		else $error("distance validity does not follow thresholds");
	AST_FLASH_UNLOCK: assert property (flash_op_o
		|-> $past(unlock_reg) == tcr_pkg::UNLOCK_FLASH && unlock_reg == 16'h0000)
		else $error("flash operation without unlock");
	AST_TEST_LOCKED: assert property (wr_to(dp_wr_reg, dp_idx_reg, tcr_pkg::IDX_TEST_CFG)
		&& unlock_reg != tcr_pkg::UNLOCK_TEST |=> $stable(test_cfg_reg))
		else $error("test configuration written while locked");
	AST_READ_WAIT: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read did not take exactly one wait state");
	CV_OVT_ENTRY: cover property (!ovt_reg ##1 ovt_reg);
	CV_FLASH_OP: cover property (flash_op_o);
	CV_SERIAL_HI_READ: cover property (rd_pend_reg && dp_idx_reg == IDX_W'(tcr_pkg::IDX_SERIAL_HI));
endmodule

/* tb_tof_camera_config_regs.sv */
// directed bench of the camera register bank over AHB-Lite
// assumes one slave, so hreadyout is fed back as hready
module tb_tof_camera_config_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, hwr = 0, fr = 0, cd = 0, cf = 0, rdy, pv, irq, hs, mt, fo;
	logic [1:0] ht = 0;
	logic [31:0] ha = 0, hw = 0, hr;
	logic [15:0] amp = 0, v, c, fc;
	tcr_pkg::tcr_sense_s sn;
	tcr_pkg::tcr_cal_req_s cq;
	tcr_pkg::tcr_ctrl_s ct;
	int mismatches = 0, checked = 0, n;
	always #10 clk = ~clk;
	tcr_config_regs uut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(ha), .htrans_i(ht),
		.hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hw), .hready_i(rdy), .hrdata_o(hr), .hreadyout_o(rdy),
		.hresp_o(hs), .sense_i(sn), .frame_captured_i(fr), .pixel_amp_i(amp), .cal_done_i(cd),
		.cal_fail_i(cf), .pixel_valid_o(pv), .ctrl_o(ct), .cal_req_o(cq), .manual_trigger_o(mt),
		.flash_op_o(fo), .flash_cmd_o(fc), .irq_o(irq));
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic wr, input logic [8:0] i, input logic [15:0] d);
		ht <= 2'h2;
		hwr <= wr;
		ha <= {21'h0, i, 2'h0};
		for (int p = 0; p < 2; p++) begin
			tk(1);
			for (n = 0; rdy !== 1'b1 && n < 40; n++)
				tk(1);
			if (rdy !== 1'b1) begin
				mismatches++;
				report_and_stop;
			end
			// data phase goes on once; a second drive here would clash with a back-to-back request
			if (p == 0) begin
				ht <= 2'h0;
				hw <= {16'h0, d};
			end
		end
		v = hr[15:0];
	endtask
	task automatic rc(input logic [8:0] i, input logic [15:0] e);
		bus(1'b0, i, 16'h0000);
		chk(v, e);
	endtask
	task automatic pl(input int w);
		fr <= w == 0;
		cf <= w == 1;
		cd <= w == 2;
		tk(1);
		{fr, cf, cd} <= 3'h0;
		tk(1);
	endtask
	initial begin
		sn <= '{32'hA5C31E7B, 16'h0, 1'b0, 16'h0, 16'h0, 1'b1, 1'b1, 1'b1, 16'h1234};
		tk(4);
		rst <= 1'b0;
		tk(1);
		rc(tcr_pkg::IDX_MOD_FREQ, 16'h07D0);
		rc(tcr_pkg::IDX_TEMP_LIMIT, 16'h1B58);
		rc(tcr_pkg::IDX_ILLUM_TEMP, 16'hFFFF);
		bus(1'b1, tcr_pkg::IDX_SERIAL_LO, 16'h0000);
		rc(tcr_pkg::IDX_SERIAL_LO, 16'h1E7B);
		rc(tcr_pkg::IDX_SERIAL_HI, 16'hA5C3);
		bus(1'b0, tcr_pkg::IDX_FRAME_CNT, 16'h0000);
		c = v;
		chk(hs, 16'h0000);
		bus(1'b1, tcr_pkg::IDX_FRAME_CNT, 16'hFFFF);
		repeat (3) pl(0);
		rc(tcr_pkg::IDX_FRAME_CNT, c + 16'h0003);
		bus(1'b1, tcr_pkg::IDX_IRQ_MASK, 16'h0001);
		rc(tcr_pkg::IDX_IRQ_STAT, 16'h0001);
		chk(irq, 16'h0001);
		bus(1'b1, tcr_pkg::IDX_IRQ_STAT, 16'h0001);
		rc(tcr_pkg::IDX_IRQ_STAT, 16'h0000);
		chk(irq, 16'h0000);
		bus(1'b1, tcr_pkg::IDX_CAL_CMD, 16'h000D);
		rc(tcr_pkg::IDX_CAL_EXT, 16'h0013);
		pl(1);
		rc(tcr_pkg::IDX_CAL_EXT, 16'h04FF);
		bus(1'b1, tcr_pkg::IDX_CAL_CMD, 16'h0010);
		rc(tcr_pkg::IDX_CAL_EXT, 16'h0014);
		chk(cq.freq, 16'h1234);
		pl(2);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, tcr_pkg::IDX_IMG_FMT, k == 0 ? 16'h0018 : 16'h0000);
			bus(1'b1, tcr_pkg::IDX_MODE, k == 1 ? 16'h0000 : 16'h0001);
			sn.mod_freq_ok <= k != 2;
			bus(1'b1, tcr_pkg::IDX_CAL_CMD, 16'h000D);
			rc(tcr_pkg::IDX_CAL_EXT, k == 2 ? 16'h04F8 : 16'h04F6);
		end
		bus(1'b1, tcr_pkg::IDX_LENS_ID, 16'h000B);
		rc(tcr_pkg::IDX_LENS_ID, 16'h000B);
		bus(1'b1, tcr_pkg::IDX_MODE, 16'h0041);
		rc(tcr_pkg::IDX_CAL_EXT, 16'h0000);
		$display("bus and calibration tests done");
		bus(1'b1, tcr_pkg::IDX_UNLOCK, 16'h4877);
		bus(1'b1, tcr_pkg::IDX_CMD_EXEC, 16'h909A);
		tk(1);
		chk(fo, 16'h0001);
		bus(1'b1, tcr_pkg::IDX_CMD_EXEC, 16'hDD9E);
		tk(1);
		chk(fo, 16'h0000);
		rc(tcr_pkg::IDX_UNLOCK, 16'h0000);
		bus(1'b1, tcr_pkg::IDX_TEST_CFG, 16'hABCD);
		rc(tcr_pkg::IDX_TEST_CFG, 16'h0000);
		bus(1'b1, tcr_pkg::IDX_UNLOCK, 16'h5E6B);
		bus(1'b1, tcr_pkg::IDX_TEST_CFG, 16'hABCD);
		rc(tcr_pkg::IDX_TEST_CFG, 16'hABCD);
		sn.temp_present <= 1'b1;
		sn.illum_temp <= 16'd7001;
		tk(4);
		chk(fc, 16'h909A);
		rc(tcr_pkg::IDX_STATUS, 16'h0200);
		chk(ct.illum_en, 16'h0000);
		sn.illum_temp <= 16'd6700;
		tk(4);
		rc(tcr_pkg::IDX_STATUS, 16'h0000);
		chk(ct.illum_en, 16'h0001);
		sn.hfov <= 16'h1F40;
		sn.fpn_stored <= 1'b0;
		sn.lens_cal_stored <= 1'b0;
		rc(tcr_pkg::IDX_HFOV, 16'h1F40);
		rc(tcr_pkg::IDX_CAL_EXT, 16'h5000);
		bus(1'b1, tcr_pkg::IDX_MODE, 16'h0010);
		tk(1);
		chk(mt, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			amp <= k < 2 ? 16'd999 + 16'(k) : 16'd59998 + 16'(k);
			tk(2);
			chk(pv, k == 1 || k == 2);
		end
		$display("unlock, temperature and pixel tests done");
		report_and_stop;
	end
endmodule
